// >>> src/cipc_top.sv
/*
 Interrupt priority control of the processor: latching, masking, priority scan,
 vector writes to low memory, sensing, clearing and the condition-state register.
 Assumes instruction strobes are one-cycle pulses from the sequencer on clk,
 and that external pins and button inputs are asynchronous and get synchronised here.
*/
`include "cipc_defs.svh"
module cipc_top #(
    parameter int CHANNELS = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [63:0] ext_line,
    input wire logic [7:0] chan_line,
    input wire logic [7:0] chan_present,
    input wire logic power_fail,
    input wire logic parity_err,
    input wire logic illegal_write,
    input wire logic executive_req,
    input wire logic ovf_fault,
    input wire logic div_fault,
    input wire logic exp_fault,
    input wire logic dec_fault,
    input wire logic srm_done,
    input wire logic rtc_tick,
    input wire logic manual_req,
    input wire logic asp_req,
    input wire logic master_clear,
    input wire logic internal_clear,
    input wire logic external_clear,
    input wire logic recog_point,
    input wire logic decimal_active,
    input wire logic [14:0] pc_in,
    input wire logic enable_interrupts_op,
    input wire logic disable_interrupts_op,
    input wire logic sense_interrupts_op,
    input wire logic sense_internal_op,
    input wire logic clear_all_interrupts_op,
    input wire logic io_clear_op,
    input wire logic clear_channel_interrupt_op,
    input wire logic [2:0] channel_sel,
    input wire logic select_release_op,
    input wire logic [63:0] select_lines,
    input wire logic set_mask_bits_op,
    input wire logic clear_mask_bits_op,
    input wire logic [11:0] mask_operand,
    input wire logic copy_status_op,
    input wire logic save_condition_state_op,
    input wire logic restore_condition_state_op,
    input wire logic [5:0] restore_value,
    input wire logic boundary_jump_set_op,
    input wire logic destructive_load_set_op,
    input wire logic relocate_operands_op,
    input wire logic relocate_instructions_op,
    input wire logic load_accumulator_op,
    input wire logic jump_op,
    input wire logic in_program_state,
    input wire logic jump_to_program_state,
    input wire logic store_recovery_op,
    input wire logic load_recovery_op,
    input wire logic [14:0] recovery_in,
    output logic mem_we,
    output logic [14:0] mem_addr,
    output logic [23:0] mem_wdata,
    output logic [23:0] mem_wmask,
    output logic jump_req,
    output logic [14:0] jump_addr,
    output logic interrupt_stop,
    output logic [23:0] acc_out,
    output logic acc_valid,
    output logic int_enabled,
    output logic [14:0] recovery_out
);
    // Two-stage synchronisers for all asynchronous inputs.
    localparam int NA = 64 + 8 + 15;
    logic [NA-1:0] sy1_ff, sy2_ff;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sy1_ff <= '0;
            sy2_ff <= '0;
        end else begin
            sy1_ff <= {ext_line, chan_line, power_fail, parity_err, illegal_write,
                executive_req, ovf_fault, div_fault, exp_fault, dec_fault, srm_done,
                rtc_tick, manual_req, asp_req, master_clear, internal_clear,
                external_clear};
            sy2_ff <= sy1_ff;
        end
    end
    logic [63:0] s_ext;
    logic [7:0] s_chan;
    logic s_pf, s_par, s_iw, s_exe, s_ovf, s_div, s_exp, s_dec, s_srm, s_rtc;
    logic s_man, s_asp, s_mc, s_ic, s_xc;
    assign {s_ext, s_chan, s_pf, s_par, s_iw, s_exe, s_ovf, s_div, s_exp, s_dec, s_srm,
        s_rtc, s_man, s_asp, s_mc, s_ic, s_xc} = sy2_ff;

    logic [11:0] mask_ff, nxt_mask;
    logic [5:0] cs_ff, nxt_cs;
    logic [14:0] rec_ff, nxt_rec;
    logic enable_ff, nxt_enable;
    cipc_pkg::cipc_state_type st_ff, nxt_st;
    logic [14:0] ret_ff, nxt_ret;
    logic [14:0] vec_ff, nxt_vec;
    logic [11:0] code_ff, nxt_code;
    logic [7:0] int_clr, int_set, int_q;
    logic [7:0] ch_clr, ch_q;
    logic [63:0] ex_clr, ex_q;
    logic take;

    // Internal bits: 0 ovf, 1 div, 2 exp, 3 dec, 4 srm, 5 rtc, 6 man, 7 asp.
    assign int_set = {s_asp, s_man, s_rtc, s_srm, s_dec, s_exp, s_div, s_ovf};
    logic sense_any;
    assign sense_any = sense_interrupts_op | sense_internal_op;
    logic [7:0] man_asp_taken;
    always_comb begin
        int_clr = '0;
        if (sense_any) begin
            int_clr[5:0] = 6'h3F;
        end
        if (clear_all_interrupts_op || s_mc || s_ic) begin
            int_clr = 8'hFF;
        end
        if (io_clear_op) begin
            int_clr[4] = 1'b1;
        end
        int_clr = int_clr | man_asp_taken;
    end
    always_comb begin
        ch_clr = '0;
        if (clear_all_interrupts_op || io_clear_op || s_mc || s_xc) begin
            ch_clr = 8'hFF;
        end
        if (clear_channel_interrupt_op) begin
            ch_clr[channel_sel] = 1'b1;
        end
    end
    always_comb begin
        ex_clr = select_release_op ? select_lines : 64'h0;
        if (io_clear_op || s_mc || s_xc) begin
            ex_clr = '1;
        end
    end

    cipc_req_latch #(.WIDTH(8)) u_int (.clk(clk), .rstn(rstn), .set(int_set),
        .clr(int_clr), .q(int_q));
    cipc_req_latch #(.WIDTH(8)) u_chan (.clk(clk), .rstn(rstn), .set(s_chan),
        .clr(ch_clr), .q(ch_q));
    cipc_req_latch #(.WIDTH(64)) u_ext (.clk(clk), .rstn(rstn), .set(s_ext),
        .clr(ex_clr), .q(ex_q));

    // Absent channels 0 and 1 always look active to sensing; the scanner skips the lines of channels clear in chan_present or mask_ff, whatever CHANNELS is.
    logic [63:0] ext_view;
    always_comb begin
        ext_view = ex_q;
        for (int c = 0; c < 8; c++) begin
            if (!chan_present[c] || c >= CHANNELS) begin
                ext_view[c*8 +: 8] = 8'hFF;
            end
        end
    end

    // Priority scan, one combinational walk per recognition point.
    logic found, pf_win;
    logic [11:0] win_code;
    logic [7:0] win_int;
    logic [7:0] live_ch;
    assign live_ch = chan_present;
    always_comb begin
        found = 1'b0;
        pf_win = 1'b0;
        win_code = '0;
        win_int = '0;
        if (s_par || s_iw) begin
            found = 1'b0; // No vector is taken while a parity or illegal-write error is present.
        end else if (s_pf) begin
            found = 1'b1;
            pf_win = 1'b1;
            win_code = `CIPC_CODE_PF;
        end else if (s_exe) begin
            found = 1'b1;
            win_code = `CIPC_CODE_EXE;
        end else if (enable_ff) begin
            if (int_q[0] && mask_ff[`CIPC_MASK_OVF]) begin
                found = 1'b1;
                win_code = `CIPC_CODE_OVF;
                win_int[0] = 1'b1;
            end else if (int_q[1] && mask_ff[`CIPC_MASK_OVF]) begin
                found = 1'b1;
                win_code = `CIPC_CODE_DIV;
                win_int[1] = 1'b1;
            end else if (int_q[2] && mask_ff[`CIPC_MASK_EXP]) begin
                found = 1'b1;
                win_code = `CIPC_CODE_EXP;
                win_int[2] = 1'b1;
            end else if (int_q[3] && mask_ff[`CIPC_MASK_EXP]) begin
                found = 1'b1;
                win_code = `CIPC_CODE_DEC;
                win_int[3] = 1'b1;
            end
            // Line-major walk: line 0 of every channel before line 1.
            for (int l = 7; l >= 0; l--) begin
                for (int c = 7; c >= 0; c--) begin
                    if (!found && ex_q[c*8+l] && live_ch[c] && mask_ff[c]) begin
                        win_code = {6'h00, l[2:0], c[2:0]};
                    end
                end
            end
            if (!found && |(ex_q & {{8{live_ch[7]&&mask_ff[7]}}, {8{live_ch[6]&&mask_ff[6]}},
                {8{live_ch[5]&&mask_ff[5]}}, {8{live_ch[4]&&mask_ff[4]}},
                {8{live_ch[3]&&mask_ff[3]}}, {8{live_ch[2]&&mask_ff[2]}},
                {8{live_ch[1]&&mask_ff[1]}}, {8{live_ch[0]&&mask_ff[0]}}})) begin
                found = 1'b1;
            end
            for (int c = 7; c >= 0; c--) begin
                if (!found && ch_q[c] && mask_ff[c]) begin
                    win_code = `CIPC_CODE_CHAN | {9'h000, c[2:0]};
                end
            end
            if (!found && |(ch_q & mask_ff[7:0])) begin
                found = 1'b1;
            end else if (!found && int_q[4] && mask_ff[`CIPC_MASK_SRM]) begin
                found = 1'b1;
                win_code = `CIPC_CODE_SRM;
                win_int[4] = 1'b1;
            end else if (!found && int_q[5] && mask_ff[`CIPC_MASK_RTC]) begin
                found = 1'b1;
                win_code = `CIPC_CODE_RTC;
                win_int[5] = 1'b1;
            end else if (!found && int_q[6]) begin
                found = 1'b1;
                win_code = `CIPC_CODE_MAN;
                win_int[6] = 1'b1;
            end else if (!found && int_q[7]) begin
                found = 1'b1;
                win_code = `CIPC_CODE_ASP;
                win_int[7] = 1'b1;
            end
        end
    end
    assign take = (st_ff == cipc_pkg::cipc_idle_type_s) && recog_point && found;
    assign man_asp_taken = take ? (win_int & 8'hC0) : 8'h00;

    // Vector sequencer: save P, write cause except on power fail, then jump.
    logic pf_ff, nxt_pf;
    always_comb begin
        nxt_st = st_ff;
        nxt_ret = ret_ff;
        nxt_vec = vec_ff;
        nxt_code = code_ff;
        nxt_pf = pf_ff;
        case (st_ff)
            cipc_pkg::cipc_idle_type_s: begin
                if (take) begin
                    nxt_ret = pc_in;
                    nxt_code = win_code;
                    nxt_pf = pf_win;
                    nxt_vec = pf_win ? `CIPC_PF_GO : `CIPC_VEC;
                    nxt_st = cipc_pkg::cipc_save_type_s;
                end
            end
            cipc_pkg::cipc_save_type_s: begin
                nxt_st = pf_ff ? cipc_pkg::cipc_done_type_s : cipc_pkg::cipc_code_type_s;
            end
            cipc_pkg::cipc_code_type_s: begin
                nxt_st = cipc_pkg::cipc_done_type_s;
            end
            default: begin
                nxt_st = cipc_pkg::cipc_idle_type_s;
            end
        endcase
    end

    // Enable, mask, condition state and recovery register.
    logic [23:0] acc_nxt;
    logic acc_v_nxt;
    always_comb begin
        nxt_enable = enable_ff;
        nxt_mask = mask_ff;
        nxt_cs = cs_ff;
        nxt_rec = rec_ff;
        acc_nxt = acc_out;
        acc_v_nxt = 1'b0;
        if (enable_interrupts_op) nxt_enable = 1'b1;
        if (disable_interrupts_op) nxt_enable = 1'b0;
        if (restore_condition_state_op) nxt_enable = restore_value[`CIPC_CS_ENA];
        if (take) nxt_enable = 1'b0;
        if (set_mask_bits_op) nxt_mask = nxt_mask | mask_operand;
        if (clear_mask_bits_op) nxt_mask = nxt_mask & ~mask_operand;
        if (boundary_jump_set_op) nxt_cs[`CIPC_CS_BJP] = 1'b1;
        else if (jump_op) nxt_cs[`CIPC_CS_BJP] = 1'b0;
        if (destructive_load_set_op) nxt_cs[`CIPC_CS_DLD] = 1'b1;
        else if (load_accumulator_op) nxt_cs[`CIPC_CS_DLD] = 1'b0;
        if (relocate_operands_op) nxt_cs[`CIPC_CS_REL] = 1'b1;
        else if (relocate_instructions_op) nxt_cs[`CIPC_CS_REL] = 1'b0;
        if (jump_to_program_state) begin
            nxt_cs[`CIPC_CS_PSJ] = 1'b0;
            nxt_cs[`CIPC_CS_TOP] = 1'b1;
        end else if (jump_op && in_program_state) begin
            nxt_cs[`CIPC_CS_PSJ] = 1'b1;
        end
        nxt_cs[`CIPC_CS_ENA] = nxt_enable;
        if (restore_condition_state_op) nxt_cs = restore_value;
        if (save_condition_state_op) begin
            acc_nxt = {18'h00000, cs_ff};
            acc_v_nxt = 1'b1;
            nxt_cs = '0;
            nxt_enable = 1'b0;
        end
        if (copy_status_op) begin
            acc_nxt = {mask_ff, 12'h000};
            acc_v_nxt = 1'b1;
        end
        if (sense_any) begin
            acc_nxt = {ext_view[15:0], int_q};
            acc_v_nxt = 1'b1;
        end
        if (load_recovery_op || decimal_active) nxt_rec = recovery_in;
        if (store_recovery_op) begin
            acc_nxt = {9'h000, rec_ff};
            acc_v_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_ff <= cipc_pkg::cipc_idle_type_s;
            ret_ff <= '0;
            vec_ff <= '0;
            code_ff <= '0;
            pf_ff <= 1'b0;
            enable_ff <= 1'b0;
            mask_ff <= '0;
            cs_ff <= '0;
            rec_ff <= '0;
            acc_out <= '0;
            acc_valid <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            ret_ff <= nxt_ret;
            vec_ff <= nxt_vec;
            code_ff <= nxt_code;
            pf_ff <= nxt_pf;
            enable_ff <= nxt_enable;
            mask_ff <= nxt_mask;
            cs_ff <= nxt_cs;
            rec_ff <= nxt_rec;
            acc_out <= acc_nxt;
            acc_valid <= acc_v_nxt;
        end
    end

    // Memory and jump outputs, all registered.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mem_we <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= '0;
            mem_wmask <= '0;
            jump_req <= 1'b0;
            jump_addr <= '0;
            interrupt_stop <= 1'b0;
            int_enabled <= 1'b0;
            recovery_out <= '0;
        end else begin
            mem_we <= (nxt_st == cipc_pkg::cipc_save_type_s) ||
                (nxt_st == cipc_pkg::cipc_code_type_s);
            mem_addr <= (nxt_st == cipc_pkg::cipc_code_type_s) ? `CIPC_VEC :
                (nxt_pf ? `CIPC_PF_SAVE : `CIPC_SAVE);
            mem_wdata <= (nxt_st == cipc_pkg::cipc_code_type_s) ? {12'h000, nxt_code} :
                {9'h000, nxt_ret};
            mem_wmask <= (nxt_st == cipc_pkg::cipc_code_type_s) ? 24'h000FFF :
                24'h007FFF;
            jump_req <= (nxt_st == cipc_pkg::cipc_done_type_s);
            jump_addr <= nxt_vec;
            interrupt_stop <= decimal_active && found;
            int_enabled <= nxt_enable;
            recovery_out <= nxt_rec;
        end
    end
endmodule // cipc_top

// >>> src/cipc_defs.svh
/*
 Constants and field positions of the interrupt priority control block.
 Assumes the includer compiles it once per compilation unit; the guard makes repeats harmless.
*/
`ifndef CIPC_DEFS_SVH
`define CIPC_DEFS_SVH
`define CIPC_ADDR_W 15
`define CIPC_WORD_W 24
`define CIPC_CODE_W 12
`define CIPC_PF_SAVE 15'h0002
`define CIPC_PF_GO 15'h0003
`define CIPC_SAVE 15'h0004
`define CIPC_VEC 15'h0005
`define CIPC_MASK_RTC 8
`define CIPC_MASK_EXP 9
`define CIPC_MASK_OVF 10
`define CIPC_MASK_SRM 11
`define CIPC_CS_BJP 0
`define CIPC_CS_DLD 1
`define CIPC_CS_REL 2
`define CIPC_CS_PSJ 3
`define CIPC_CS_ENA 4
`define CIPC_CS_TOP 5
`define CIPC_CODE_CHAN 12'h040
`define CIPC_CODE_RTC 12'h048
`define CIPC_CODE_OVF 12'h049
`define CIPC_CODE_DIV 12'h04A
`define CIPC_CODE_EXP 12'h04B
`define CIPC_CODE_DEC 12'h04C
`define CIPC_CODE_SRM 12'h04D
`define CIPC_CODE_MAN 12'h04E
`define CIPC_CODE_ASP 12'h04F
`define CIPC_CODE_EXE 12'h04F
`define CIPC_CODE_PF 12'h000
`endif

// >>> src/cipc_pkg.sv
/*
 Types shared by the interrupt priority control files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cipc_pkg;
    typedef enum logic [1:0] {
        cipc_idle_type_s,
        cipc_save_type_s,
        cipc_code_type_s,
        cipc_done_type_s
    } cipc_state_type;
endpackage

// >>> src/cipc_req_latch.sv
/*
 Sticky request latch: holds each of its WIDTH interrupt conditions until cleared.
 Assumes set and clear come from logic on clk; the set wins a tie.
*/
module cipc_req_latch #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] q_ff;
    logic [WIDTH-1:0] nxt_q;

    // A request that lands in the clearing cycle survives to the next scan.
    always_comb begin
        nxt_q = (q_ff & ~clr) | set;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q = q_ff;
endmodule // cipc_req_latch

// >>> dv/cipc_top_asserts.sv
/*
 Checker for cipc_top: vector write order, saved words, enable control and status reads.
 Assumes it is bound into cipc_top and sees only that module's ports.
*/
module cipc_top_checker #(
    parameter int CHANNELS = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic recog_point,
    input wire logic [14:0] pc_in,
    input wire logic enable_interrupts_op,
    input wire logic disable_interrupts_op,
    input wire logic sense_interrupts_op,
    input wire logic copy_status_op,
    input wire logic save_condition_state_op,
    input wire logic restore_condition_state_op,
    input wire logic mem_we,
    input wire logic [14:0] mem_addr,
    input wire logic [23:0] mem_wdata,
    input wire logic [23:0] mem_wmask,
    input wire logic jump_req,
    input wire logic [14:0] jump_addr,
    input wire logic acc_valid,
    input wire logic int_enabled
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_code_write;
        mem_we && mem_addr == 15'h0005 && mem_wmask == 24'h000FFF;
    endsequence
    sequence s_vec_jump;
        !mem_we && jump_req && jump_addr == 15'h0005;
    endsequence
    property p_vec_order;
        mem_we && mem_addr == 15'h0004 |=> s_code_write ##1 s_vec_jump;
    endproperty
    a_vec_order: assert property (p_vec_order) else $error("vector order wrong");
    property p_save_pc;
        mem_we && mem_addr == 15'h0004 |-> $past(recog_point) && mem_wmask == 24'h007FFF
            && mem_wdata[14:0] == $past(pc_in);
    endproperty
    a_save_pc: assert property (p_save_pc) else $error("return word wrong");
    property p_pf_seq;
        mem_we && mem_addr == 15'h0002 |-> mem_wmask == 24'h007FFF
            && mem_wdata[14:0] == $past(pc_in) ##1 !mem_we && jump_req && jump_addr == 15'h0003;
    endproperty
    a_pf_seq: assert property (p_pf_seq) else $error("power fail entry wrong");
    property p_take_disables;
        mem_we && !enable_interrupts_op && !restore_condition_state_op |=> !int_enabled;
    endproperty
    a_take_disables: assert property (p_take_disables) else $error("still enabled");
    property p_enable;
        enable_interrupts_op && !disable_interrupts_op && !save_condition_state_op
            && !recog_point |=> int_enabled;
    endproperty
    a_enable: assert property (p_enable) else $error("enable not set");
    property p_disable;
        disable_interrupts_op && !enable_interrupts_op && !restore_condition_state_op
            |=> !int_enabled;
    endproperty
    a_disable: assert property (p_disable) else $error("enable not cleared");
    property p_acc;
        sense_interrupts_op || copy_status_op |=> acc_valid;
    endproperty
    a_acc: assert property (p_acc) else $error("no accumulator result");
    property p_jump_after_save;
        jump_req |-> $past(mem_we) && !mem_we;
    endproperty
    a_jump_after_save: assert property (p_jump_after_save) else $error("jump too early");
endmodule // cipc_top_checker

bind cipc_top cipc_top_checker #(.CHANNELS(CHANNELS)) u_cipc_top_checker (.*);

// >>> dv/cipc_seq_model.sv
/*
 Partner model: low memory words 0 to 7 and the program counter of the sequencer.
 Assumes write and jump strobes from cipc_top on clk; other addresses are dropped.
*/
module cipc_seq_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic mem_we,
    input wire logic [14:0] mem_addr,
    input wire logic [23:0] mem_wdata,
    input wire logic [23:0] mem_wmask,
    input wire logic jump_req,
    input wire logic [14:0] jump_addr,
    output logic [14:0] pc_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] mem [0:7];
    initial begin
        pc_in = 15'h0100;
        for (int i = 0; i < 8; i++) begin
            mem[i] = 24'h5A5000;
        end
    end
    // Core words keep bits outside the write mask, so a partial store shows up.
    always @(posedge clk) begin
        if (mem_we && mem_addr < 15'h0008) begin
            mem[mem_addr[2:0]] <= (mem[mem_addr[2:0]] & ~mem_wmask) | (mem_wdata & mem_wmask);
        end
        if (!rstn) begin
            pc_in <= 15'h0100;
        end else if (jump_req) begin
            pc_in <= jump_addr;
        end
    end
endmodule // cipc_seq_model

// >>> dv/cipc_top_bench.sv
/*
 Self-checking bench for cipc_top with the sequencer memory model.
 Assumes the checker is bound in by its own file.
*/
module cipc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, power_fail, parity_err, illegal_write, executive_req, ovf_fault;
    logic div_fault, exp_fault, dec_fault, srm_done, rtc_tick, manual_req, asp_req;
    logic master_clear, internal_clear, external_clear, recog_point, decimal_active;
    logic in_program_state, jump_to_program_state, hit;
    logic [63:0] ext_line, select_lines;
    logic [7:0] chan_line, chan_present;
    logic [14:0] pc_in, recovery_in, pc_seen, mem_addr, jump_addr, recovery_out;
    logic [2:0] channel_sel;
    logic [11:0] mask_operand;
    logic [5:0] restore_value;
    logic [20:0] op;
    logic enable_interrupts_op, disable_interrupts_op, sense_interrupts_op, sense_internal_op;
    logic clear_all_interrupts_op, io_clear_op, clear_channel_interrupt_op, select_release_op;
    logic set_mask_bits_op, clear_mask_bits_op, copy_status_op, save_condition_state_op;
    logic restore_condition_state_op, boundary_jump_set_op, destructive_load_set_op;
    logic relocate_operands_op, relocate_instructions_op, load_accumulator_op, jump_op;
    logic store_recovery_op, load_recovery_op, mem_we, jump_req, interrupt_stop;
    logic acc_valid, int_enabled;
    logic [23:0] mem_wdata, mem_wmask, acc_out;
    int failures, tests_run, cycles;
    localparam int op_en = 0, op_sense = 2, op_clr_all = 4, op_io_clr = 5, op_clr_ch = 6;
    localparam int op_sel_rel = 7, op_set_mask = 8, op_clr_mask = 9, op_copy = 10;
    localparam int op_save = 11, op_restore = 12, op_bjp = 13;
    assign {load_recovery_op, store_recovery_op, jump_op, load_accumulator_op,
        relocate_instructions_op, relocate_operands_op, destructive_load_set_op,
        boundary_jump_set_op, restore_condition_state_op, save_condition_state_op,
        copy_status_op, clear_mask_bits_op, set_mask_bits_op, select_release_op,
        clear_channel_interrupt_op, io_clear_op, clear_all_interrupts_op, sense_internal_op,
        sense_interrupts_op, disable_interrupts_op, enable_interrupts_op} = op;
    cipc_top u_cipc_top (.*);
    cipc_seq_model u_cipc_seq_model (.*);
    initial clk = 1'b0;
    always #5 clk = ~clk;
    task automatic wrap_up;
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic strobe(input int b);
        @(posedge clk);
        op <= 21'h000001 << b;
        @(posedge clk);
        op <= '0;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask
    task automatic read_acc(input int b);
        strobe(b);
        @(negedge clk);
    endtask
    // The window is wide enough to see the save, the code write, the jump and the new P.
    task automatic take;
        @(posedge clk);
        pc_seen = pc_in;
        recog_point <= 1'b1;
        @(posedge clk);
        recog_point <= 1'b0;
        hit = 1'b0;
        repeat (6) begin
            @(negedge clk);
            hit = hit | (mem_we === 1'b1);
        end
    endtask
    initial begin
        {rstn, power_fail, parity_err, illegal_write, executive_req, ovf_fault, div_fault,
            exp_fault, dec_fault, srm_done, rtc_tick, manual_req, asp_req, master_clear,
            internal_clear, external_clear, recog_point, decimal_active, in_program_state,
            jump_to_program_state} = '0;
        {ext_line, select_lines, chan_line, recovery_in, channel_sel, mask_operand} = '0;
        {restore_value, op} = '0;
        chan_present = 8'hFD;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk({23'h000000, int_enabled}, 24'h000000);
        read_acc(op_copy);
        chk({12'h000, acc_out[23:12]}, 24'h000000);
        mask_operand <= 12'h805;
        strobe(op_set_mask);
        mask_operand <= 12'h801;
        strobe(op_clr_mask);
        read_acc(op_copy);
        chk({12'h000, acc_out[23:12]}, 24'h000004);
        chan_line <= 8'h04;
        settle();
        take();
        chk({23'h000000, hit}, 24'h000000);
        strobe(op_en);
        @(negedge clk);
        chk({23'h000000, int_enabled}, 24'h000001);
        take();
        chk({9'h000, u_cipc_seq_model.mem[4][14:0]}, {9'h000, pc_seen});
        chk(u_cipc_seq_model.mem[5], 24'h5A5042);
        chk({9'h000, pc_in}, 24'h000005);
        chk({23'h000000, int_enabled}, 24'h000000);
        chan_line <= 8'h00;
        settle();
        channel_sel <= 3'h2;
        strobe(op_clr_ch);
        strobe(op_en);
        take();
        chk({23'h000000, hit}, 24'h000000);
        mask_operand <= 12'h0FF;
        strobe(op_set_mask);
        ext_line <= 64'h0000000000010008;
        chan_line <= 8'h01;
        settle();
        take();
        chk(u_cipc_seq_model.mem[5], 24'h5A5002);
        ext_line <= 64'h0000000000000008;
        settle();
        select_lines <= 64'h0000000000010000;
        strobe(op_sel_rel);
        strobe(op_en);
        take();
        chk(u_cipc_seq_model.mem[5], 24'h5A5018);
        ext_line <= 64'h0000000000000000;
        settle();
        strobe(op_io_clr);
        strobe(op_en);
        take();
        chk(u_cipc_seq_model.mem[5], 24'h5A5040);
        chan_line <= 8'h00;
        settle();
        strobe(op_clr_all);
        strobe(op_en);
        take();
        chk({23'h000000, hit}, 24'h000000);
        ovf_fault <= 1'b1;
        settle();
        ovf_fault <= 1'b0;
        settle();
        read_acc(op_sense);
        chk(acc_out, 24'hFF0001);
        read_acc(op_sense);
        chk(acc_out, 24'hFF0000);
        parity_err <= 1'b1;
        power_fail <= 1'b1;
        settle();
        take();
        chk({23'h000000, hit}, 24'h000000);
        parity_err <= 1'b0;
        settle();
        take();
        chk({9'h000, u_cipc_seq_model.mem[2][14:0]}, {9'h000, pc_seen});
        chk({9'h000, pc_in}, 24'h000003);
        chk(u_cipc_seq_model.mem[5], 24'h5A5040);
        chk({23'h000000, int_enabled}, 24'h000000);
        restore_value <= 6'h10;
        recovery_in <= 15'h1234;
        strobe(op_en);
        strobe(op_bjp);
        read_acc(op_save);
        chk(acc_out, 24'h000011);
        chk({23'h000000, int_enabled}, 24'h000000);
        read_acc(op_save);
        chk(acc_out, 24'h000000);
        strobe(op_restore);
        @(negedge clk);
        chk({23'h000000, int_enabled}, 24'h000001);
        decimal_active <= 1'b1;
        settle();
        @(negedge clk);
        chk({23'h000000, interrupt_stop}, 24'h000001);
        chk({9'h000, recovery_out}, 24'h001234);
        wrap_up();
    end
endmodule // cipc_top_bench
